/* File: pkg/tdac_pkg.sv */
// What this block does
// [RULE1] DAC reference chosen by field, external default
// [RULE2] Gain bit clear gives unity span
// [RULE3] Gain bit set doubles span, clamped
// [RULE4] Two enables route temperatures to DACs
// [RULE5] Thermal code refreshes on each measurement
// [RULE6] Eight-bit variant: one count per degree
// [RULE7] Wide variants default 8-bit, bit selects 10-bit
// [RULE8] Span bits double thermal span per DAC
// [RULE9] Range -128..127, zero volts at -40
// [RULE10] Signed 8-bit zero-volt temperature registers
// [RULE11] 8-bit code is temperature minus offset
// [RULE12] 10-bit code is four times difference
// [RULE13] Overflow holds code at full scale
// [RULE14] ADC reference bit: internal or supply
// [RULE15] Two-bit field assigns shared input pins
// [RULE16] ADC returns 10-bit straight binary
// [RULE17] ADC acquires then approximates bit by bit
// [RULE18] DAC output waits for load command
// [RULE19] Below offset clamps code to zero
// [RULE20] Offset sign-extended before subtraction
package tdac_pkg;
    localparam logic [7:0] ADDR_DAC_A_MSB      = 8'h10;
    localparam logic [7:0] ADDR_INPUT_PIN_CFG  = 8'h18;
    localparam logic [7:0] ADDR_CONV_OPT_CFG   = 8'h1A;
    localparam logic [7:0] ADDR_DAC_GAIN_CFG   = 8'h1B;
    localparam logic [7:0] ADDR_DAC_LOAD_CFG   = 8'h1C;
    localparam logic [7:0] ADDR_INT_ZERO_TEMP  = 8'h21;
    localparam logic [7:0] ADDR_EXT_ZERO_TEMP  = 8'h22;
    localparam logic [7:0] ADDR_ADC_RESULT_MSB = 8'h23;
    localparam logic [7:0] ADDR_ADC_RESULT_LSB = 8'h24;
    localparam logic [7:0] RST_INPUT_PIN_CFG   = 8'h00;
    localparam logic [7:0] RST_CONV_OPT_CFG    = 8'h00;
    localparam logic [7:0] RST_DAC_GAIN_CFG    = 8'h00;
    localparam logic [7:0] RST_DAC_LOAD_CFG    = 8'h00;
    localparam logic [7:0] RST_ZERO_TEMP       = 8'hD8;
    localparam int BIT_THERM_10BIT     = 1;
    localparam int BIT_LOAD_SW_SELECT  = 3;
    localparam int BIT_ADC_REF_SUPPLY  = 4;
    localparam int BIT_INT_THERM_EN    = 5;
    localparam int BIT_EXT_THERM_EN    = 6;
    localparam int BIT_DAC_A_DBL_SPAN  = 0;
    localparam int BIT_DAC_B_DBL_SPAN  = 1;
    localparam int BIT_PIN_FIELD_LO    = 1;
    localparam int BIT_INT_REF_SELECT  = 4;
    localparam int BIT_SW_LOAD_CMD     = 7;
    localparam int ADC_BITS            = 10;
    localparam int TEMP_BITS           = 10;
endpackage

/* File: rtl/tdac_sar.sv */
module tdac_sar
    import tdac_pkg::*;
(
    input  wire logic                i_sys_clk,
    input  wire logic                i_resetn,
    input  wire logic                i_start,
    input  wire logic                i_comp_high,
    output logic [tdac_pkg::ADC_BITS-1:0] o_trial,
    output logic                     o_sample,
    output logic [tdac_pkg::ADC_BITS-1:0] o_result,
    output logic                     o_done
);
    typedef enum logic [1:0] {S_IDLE, S_ACQ, S_CONV} tdac_sar_e;
    typedef struct packed {
        tdac_sar_e           st;
        logic [ADC_BITS-1:0] trial;
        logic [ADC_BITS-1:0] bitm;
        logic [ADC_BITS-1:0] result;
        logic                done;
        logic                sample;
    } tdac_sar_s;
    tdac_sar_s s_reg, s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        case (s_reg.st)
            S_IDLE: begin
                if (i_start) begin
                    s_next.st = S_ACQ; // [RULE17]
                    s_next.sample = 1'b1;
                end
            end
            S_ACQ: begin
                s_next.sample = 1'b0;
                s_next.bitm = {1'b1, {(ADC_BITS-1){1'b0}}};
                s_next.trial = {1'b1, {(ADC_BITS-1){1'b0}}};
                s_next.st = S_CONV;
            end
            S_CONV: begin
                // Keep bit when input is above trial level
                if (!i_comp_high)
                    s_next.trial = s_reg.trial & ~s_reg.bitm; // [RULE17]
                s_next.bitm = s_reg.bitm >> 1;
                if (s_reg.bitm[0]) begin
                    s_next.result = i_comp_high ? s_reg.trial
                                  : (s_reg.trial & ~s_reg.bitm); // [RULE16]
                    s_next.done = 1'b1;
                    s_next.st = S_IDLE;
                end else begin
                    s_next.trial = s_next.trial | (s_reg.bitm >> 1);
                end
            end
            default: s_next.st = S_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end

    assign o_trial  = s_reg.trial;
    assign o_sample = s_reg.sample;
    assign o_result = s_reg.result;
    assign o_done   = s_reg.done;
endmodule // tdac_sar

/* File: rtl/tdac_ctrl.sv */
module tdac_ctrl
    import tdac_pkg::*;
#(
    parameter int DAC_BITS = 12
) (
    input  wire logic                i_sys_clk,
    input  wire logic                i_resetn,
    input  wire logic                i_reg_wr,
    input  wire logic                i_reg_rd,
    input  wire logic [7:0]          i_reg_addr,
    input  wire logic [7:0]          i_reg_wdata,
    output logic [7:0]               o_reg_rdata,
    input  wire logic                i_dac_load_strobe_n,
    input  wire logic                i_int_temp_valid,
    input  wire logic [tdac_pkg::TEMP_BITS-1:0] i_int_temp,
    input  wire logic                i_ext_temp_valid,
    input  wire logic [tdac_pkg::TEMP_BITS-1:0] i_ext_temp,
    input  wire logic                i_adc_start,
    input  wire logic                i_adc_comp_high,
    output logic [tdac_pkg::ADC_BITS-1:0] o_adc_trial,
    output logic                     o_adc_sample,
    output logic                     o_adc_done,
    output logic                     o_adc_ref_supply_select,
    output logic [1:0]               o_input_pin_mode,
    output logic                     o_dac_ref_internal,
    output logic [3:0]               o_dac_double_gain,
    output logic [4*DAC_BITS-1:0]    o_dac_codes
);
    localparam int CW = DAC_BITS;
    localparam int DW = TEMP_BITS + 4;

    typedef struct packed {
        logic [7:0]          pin_cfg;
        logic [7:0]          opt_cfg;
        logic [7:0]          gain_cfg;
        logic [7:0]          load_cfg;
        logic [7:0]          int_zero;
        logic [7:0]          ext_zero;
        logic [4*CW-1:0]     staged;
        logic [4*CW-1:0]     active;
        logic [2:0]          ldn_sync;
        logic                ldn_state;
        logic [ADC_BITS-1:0] adc_res;
        logic                adc_done;
        logic [7:0]          rdata;
    } tdac_ctrl_s;
    tdac_ctrl_s r_reg, r_next;

    logic [ADC_BITS-1:0] sar_trial;
    logic                sar_sample;
    logic [ADC_BITS-1:0] sar_result;
    logic                sar_done;

    tdac_sar u_sar (
        .i_sys_clk   (i_sys_clk),
        .i_resetn    (i_resetn),
        .i_start     (i_adc_start),
        .i_comp_high (i_adc_comp_high),
        .o_trial     (sar_trial),
        .o_sample    (sar_sample),
        .o_result    (sar_result),
        .o_done      (sar_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Thermal code: sign-extended offset, scale, clamp
    function automatic logic [CW-1:0] therm_code(
        input logic [TEMP_BITS-1:0] temp,
        input logic [7:0]           zero,
        input logic                 wide
    );
        logic signed [DW-1:0] t;
        logic signed [DW-1:0] z;
        logic signed [DW-1:0] d;
        logic signed [DW-1:0] lim;
        logic                 use_wide;
        use_wide = wide && CW >= 10;
        t = DW'(signed'(temp));
        z = DW'(signed'({zero, 2'b00})); // [RULE20] [RULE10]
        d = t - z;
        if (use_wide) begin
            lim = DW'(1023); // [RULE12] [RULE7]
        end else begin
            d = d >>> 2; // [RULE11] [RULE6]
            lim = DW'(255);
        end
        if (d < 0)
            therm_code = '0; // [RULE19]
        else if (d > lim)
            therm_code = CW'(lim) << (CW - (use_wide ? 10 : 8)); // [RULE13]
        else
            therm_code = CW'(d) << (CW - (use_wide ? 10 : 8));
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic load_now;
        logic ld_fall;
        logic wide;
        int   idx;
        load_now = 1'b0;
        ld_fall = 1'b0;
        wide = 1'b0;
        idx = 0;
        r_next = r_reg;
        r_next.ldn_sync = {r_reg.ldn_sync[1:0], i_dac_load_strobe_n};
        if (r_reg.ldn_sync[2] == r_reg.ldn_sync[1]) begin
            r_next.ldn_state = r_reg.ldn_sync[2];
            ld_fall = r_reg.ldn_state && !r_reg.ldn_sync[2];
        end
        if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_INPUT_PIN_CFG: r_next.pin_cfg  = i_reg_wdata; // [RULE15]
                ADDR_CONV_OPT_CFG:  r_next.opt_cfg  = i_reg_wdata;
                ADDR_DAC_GAIN_CFG:  r_next.gain_cfg = i_reg_wdata;
                ADDR_DAC_LOAD_CFG:  r_next.load_cfg = i_reg_wdata; // [RULE1]
                ADDR_INT_ZERO_TEMP: r_next.int_zero = i_reg_wdata; // [RULE10]
                ADDR_EXT_ZERO_TEMP: r_next.ext_zero = i_reg_wdata;
                default: begin
                    if (i_reg_addr >= ADDR_DAC_A_MSB &&
                        i_reg_addr < ADDR_INPUT_PIN_CFG) begin
                        idx = int'(i_reg_addr[2:1]);
                        if (!i_reg_addr[0])
                            r_next.staged[idx*CW+CW-8 +: 8] = i_reg_wdata;
                        else
                            r_next.staged[idx*CW +: 8] = i_reg_wdata;
                    end
                end
            endcase
        end
        // Pin load unless software load is selected
        if (r_reg.opt_cfg[BIT_LOAD_SW_SELECT])
            load_now = i_reg_wr && i_reg_addr == ADDR_DAC_LOAD_CFG &&
                       i_reg_wdata[BIT_SW_LOAD_CMD];
        else
            load_now = ld_fall;
        if (load_now)
            r_next.active = r_reg.staged; // [RULE18]
        wide = r_reg.opt_cfg[BIT_THERM_10BIT];
        if (r_reg.opt_cfg[BIT_INT_THERM_EN] && i_int_temp_valid) // [RULE4]
            r_next.active[0 +: CW] =
                therm_code(i_int_temp, r_reg.int_zero, wide); // [RULE5]
        if (r_reg.opt_cfg[BIT_EXT_THERM_EN] && i_ext_temp_valid) // [RULE4]
            r_next.active[CW +: CW] =
                therm_code(i_ext_temp, r_reg.ext_zero, wide); // [RULE5]
        r_next.adc_done = sar_done;
        if (sar_done)
            r_next.adc_res = sar_result; // [RULE16]
        case (i_reg_addr)
            ADDR_INPUT_PIN_CFG:  r_next.rdata = r_reg.pin_cfg;
            ADDR_CONV_OPT_CFG:   r_next.rdata = r_reg.opt_cfg;
            ADDR_DAC_GAIN_CFG:   r_next.rdata = r_reg.gain_cfg;
            ADDR_DAC_LOAD_CFG:   r_next.rdata = {1'b0, r_reg.load_cfg[6:0]};
            ADDR_INT_ZERO_TEMP:  r_next.rdata = r_reg.int_zero;
            ADDR_EXT_ZERO_TEMP:  r_next.rdata = r_reg.ext_zero;
            ADDR_ADC_RESULT_MSB: r_next.rdata = r_reg.adc_res[9:2];
            ADDR_ADC_RESULT_LSB: r_next.rdata = {6'h00, r_reg.adc_res[1:0]};
            default:             r_next.rdata = 8'h00;
        endcase
        if (!i_reg_rd)
            r_next.rdata = r_reg.rdata;
    end

    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r_reg <= '0;
            r_reg.pin_cfg  <= RST_INPUT_PIN_CFG;
            r_reg.opt_cfg  <= RST_CONV_OPT_CFG;
            r_reg.gain_cfg <= RST_DAC_GAIN_CFG;
            r_reg.load_cfg <= RST_DAC_LOAD_CFG;
            r_reg.int_zero <= RST_ZERO_TEMP; // [RULE9]
            r_reg.ext_zero <= RST_ZERO_TEMP;
            r_reg.ldn_sync <= 3'h7;
            r_reg.ldn_state <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_adc_trial  = sar_trial;
    assign o_adc_sample = sar_sample;
    assign o_adc_done   = r_reg.adc_done;
    assign o_reg_rdata  = r_reg.rdata;
    assign o_adc_ref_supply_select = r_reg.opt_cfg[BIT_ADC_REF_SUPPLY]; // [RULE14]
    assign o_input_pin_mode = r_reg.pin_cfg[BIT_PIN_FIELD_LO +: 2]; // [RULE15]
    assign o_dac_ref_internal = r_reg.load_cfg[BIT_INT_REF_SELECT]; // [RULE1]
    // Thermal channels use span bits, others unity unless set
    assign o_dac_double_gain = r_reg.gain_cfg[3:0]; // [RULE2] [RULE3] [RULE8]
    assign o_dac_codes = r_reg.active;
endmodule // tdac_ctrl

/* File: dv/tdac_ctrl_assertions.sv */
module tdac_ctrl_assertions
    import tdac_pkg::*;
#(
    parameter int DAC_BITS = 12
) (
    input wire logic                  i_sys_clk,
    input wire logic                  i_resetn,
    input wire logic                  i_reg_wr,
    input wire logic [7:0]            i_reg_addr,
    input wire logic [7:0]            i_reg_wdata,
    input wire logic                  i_dac_load_strobe_n,
    input wire logic                  i_int_temp_valid,
    input wire logic                  i_ext_temp_valid,
    input wire logic                  i_adc_start,
    input wire logic                  o_adc_sample,
    input wire logic                  o_adc_done,
    input wire logic                  o_adc_ref_supply_select,
    input wire logic [1:0]            o_input_pin_mode,
    input wire logic                  o_dac_ref_internal,
    input wire logic [3:0]            o_dac_double_gain,
    input wire logic [4*DAC_BITS-1:0] o_dac_codes
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);
    logic [3:0] ld_win;
    wire logic w_gain = i_reg_wr && i_reg_addr == ADDR_DAC_GAIN_CFG;
    wire logic w_load = i_reg_wr && i_reg_addr == ADDR_DAC_LOAD_CFG;
    ////////////////////////////////////////////////////////////////////
    // Window after a load command
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
        if (!i_resetn) ld_win <= 4'h0;
        else if (!i_dac_load_strobe_n || w_load) ld_win <= 4'h8;
        else if (ld_win != 4'h0) ld_win <= ld_win - 4'h1;
    end
    ////////////////////////////////////////////////////////////////////
    a_ref_select: assert property (
        w_load |=> o_dac_ref_internal == $past(i_reg_wdata[4]))
        else $error("dac reference select wrong");
    a_gain_follow: assert property (
        w_gain |=> o_dac_double_gain == $past(i_reg_wdata[3:0]))
        else $error("dac gain bits wrong");
    a_gain_hold: assert property (
        !w_gain |=> $stable(o_dac_double_gain))
        else $error("dac gain changed without write");
    a_adc_ref: assert property (
        i_reg_wr && i_reg_addr == ADDR_CONV_OPT_CFG |=>
        o_adc_ref_supply_select == $past(i_reg_wdata[4]))
        else $error("adc reference select wrong");
    a_pin_mode: assert property (
        i_reg_wr && i_reg_addr == ADDR_INPUT_PIN_CFG |=>
        o_input_pin_mode == $past(i_reg_wdata[2:1]))
        else $error("input pin mode wrong");
    a_adc_acquire: assert property (
        i_adc_start && !o_adc_sample |-> ##[1:3] o_adc_sample)
        else $error("no acquisition after start");
    a_adc_finish: assert property (
        i_adc_start && !o_adc_sample |-> ##[10:16] o_adc_done)
        else $error("conversion did not finish in time");
    a_done_pulse: assert property (
        o_adc_done |=> !o_adc_done)
        else $error("done longer than one cycle");
    a_code_cause: assert property (
        $changed(o_dac_codes) |-> ld_win != 4'h0
        || $past(i_int_temp_valid) || $past(i_ext_temp_valid))
        else $error("dac code changed without load");
    c_adc: cover property (o_adc_done);
    c_load: cover property ($fell(i_dac_load_strobe_n));
    c_therm: cover property (i_int_temp_valid ##1 $changed(o_dac_codes));
endmodule // tdac_ctrl_assertions

bind tdac_ctrl tdac_ctrl_assertions #(.DAC_BITS(DAC_BITS)) u_chk (
    .i_sys_clk, .i_resetn, .i_reg_wr, .i_reg_addr, .i_reg_wdata,
    .i_dac_load_strobe_n, .i_int_temp_valid, .i_ext_temp_valid,
    .i_adc_start, .o_adc_sample, .o_adc_done, .o_adc_ref_supply_select,
    .o_input_pin_mode, .o_dac_ref_internal, .o_dac_double_gain,
    .o_dac_codes);

/* File: dv/tdac_ctrl_tb_top.sv */
module tdac_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import tdac_pkg::*;
    logic       clk = 0, rstn = 0, wr = 0, rd = 0, ld_n = 1;
    logic       iv = 0, ev = 0, st = 0, smp, done, rs, ri;
    logic [7:0] addr = '0, wd = '0, rdata;
    logic [9:0] it = '0, et = '0, vin = '0, trial;
    logic [1:0] pm;
    logic [3:0] gain;
    logic [47:0] codes;
    wire logic  comp = (vin >= trial);
    int         error_cnt = 0;
    int         compares = 0;
    tdac_ctrl DUT (.i_sys_clk(clk), .i_resetn(rstn), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
        .o_reg_rdata(rdata), .i_dac_load_strobe_n(ld_n),
        .i_int_temp_valid(iv), .i_int_temp(it), .i_ext_temp_valid(ev),
        .i_ext_temp(et), .i_adc_start(st), .i_adc_comp_high(comp),
        .o_adc_trial(trial), .o_adc_sample(smp), .o_adc_done(done),
        .o_adc_ref_supply_select(rs), .o_input_pin_mode(pm),
        .o_dac_ref_internal(ri), .o_dac_double_gain(gain),
        .o_dac_codes(codes));
    ////////////////////////////////////////////////////////////////////
    initial forever #5 clk = ~clk;
    initial begin
        #200000;
        error_cnt++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////////
    task chk(input string n, input logic [11:0] e, input logic [11:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) begin wr <= 1; addr <= a; wd <= d; end
        @(posedge clk) wr <= 0;
        @(negedge clk);
    endtask
    task rd_chk(input string n, input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) begin rd <= 1; addr <= a; end
        @(posedge clk) rd <= 0;
        @(negedge clk) chk(n, {4'h0, e}, {4'h0, rdata});
    endtask
    task therm(input logic x, input logic [9:0] t);
        @(posedge clk) begin
            if (x) begin ev <= 1; et <= t; end
            else begin iv <= 1; it <= t; end
        end
        @(posedge clk) begin iv <= 0; ev <= 0; end
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////
    task t_reset;
        chk("dac ref", 0, ri);
        rd_chk("pin cfg", ADDR_INPUT_PIN_CFG, 8'h00);
        rd_chk("gain cfg", ADDR_DAC_GAIN_CFG, 8'h00);
        rd_chk("int zero", ADDR_INT_ZERO_TEMP, 8'hD8);
        rd_chk("ext zero", ADDR_EXT_ZERO_TEMP, 8'hD8);
        rd_chk("unmapped", 8'h7F, 8'h00);
        $display("test reset done");
    endtask
    task t_cfg;
        wr_reg(ADDR_DAC_GAIN_CFG, 8'h05);
        chk("gain", 4'h5, gain);
        wr_reg(ADDR_CONV_OPT_CFG, 8'h10);
        chk("adc ref", 1, rs);
        wr_reg(ADDR_INPUT_PIN_CFG, 8'h06);
        chk("pin mode", 2'h3, pm);
        wr_reg(ADDR_DAC_LOAD_CFG, 8'h90);
        chk("dac ref", 1, ri);
        rd_chk("load cfg", ADDR_DAC_LOAD_CFG, 8'h10);
        wr_reg(8'h7F, 8'hFF);
        rd_chk("unmapped", 8'h7F, 8'h00);
        $display("test config done");
    endtask
    task t_thermal;
        wr_reg(ADDR_CONV_OPT_CFG, 8'h20);
        therm(0, 10'h064);
        chk("a 8bit", 12'h410, codes[11:0]);
        therm(1, 10'h064);
        chk("b off", 12'h000, codes[23:12]);
        wr_reg(ADDR_INT_ZERO_TEMP, 8'h0A);
        therm(0, 10'h014);
        chk("a below", 12'h000, codes[11:0]);
        wr_reg(ADDR_CONV_OPT_CFG, 8'h62);
        wr_reg(ADDR_EXT_ZERO_TEMP, 8'h80);
        therm(0, 10'h05A);
        chk("a 10bit", 12'h0C8, codes[11:0]);
        therm(1, 10'h1FF);
        chk("b full", 12'h3FF, {2'h0, codes[23:14]});
        wr_reg(ADDR_CONV_OPT_CFG, 8'h60);
        therm(1, 10'h1FC);
        chk("b 8bit", 12'h0FF, {4'h0, codes[23:16]});
        $display("test thermal done");
    endtask
    task t_load;
        wr_reg(ADDR_CONV_OPT_CFG, 8'h00);
        wr_reg(ADDR_DAC_A_MSB, 8'hAB);
        wr_reg(8'h11, 8'hCD);
        repeat (8) @(posedge clk);
        @(negedge clk) chk("a held", 12'h0C8, codes[11:0]);
        @(posedge clk) ld_n <= 0;
        repeat (3) @(posedge clk);
        ld_n <= 1;
        repeat (8) @(negedge clk);
        chk("a loaded", 12'hACD, codes[11:0]);
        wr_reg(ADDR_CONV_OPT_CFG, 8'h08);
        wr_reg(8'h12, 8'h5A);
        chk("b held", 12'h000, codes[23:12]);
        wr_reg(ADDR_DAC_LOAD_CFG, 8'h80);
        chk("b sw load", 12'h5A0, codes[23:12]);
        $display("test load done");
    endtask
    task t_adc;
        @(posedge clk) begin vin <= 10'h2DC; st <= 1; end
        @(posedge clk) st <= 0;
        @(negedge clk) chk("adc sample", 1, smp);
        repeat (40) if (done !== 1'b1) @(negedge clk);
        chk("adc done", 1, done);
        chk("adc trial", 12'h2DC, {2'h0, trial});
        rd_chk("adc msb", ADDR_ADC_RESULT_MSB, 8'hB7);
        rd_chk("adc lsb", ADDR_ADC_RESULT_LSB, 8'h00);
        $display("test adc done");
    endtask
    ////////////////////////////////////////////////////////////////////
    task test_done;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1;
        @(negedge clk);
        t_reset();
        t_cfg();
        t_thermal();
        t_load();
        t_adc();
        test_done();
    end
endmodule // tdac_ctrl_tb_top
